// ===== verilog/sps_map.svh
// register offsets, field positions, reset values and timing figures of the serial port
`ifndef SPS_MAP_SVH
`define SPS_MAP_SVH
// Overview of operation
// [R1] enable bit runs port, claims its pins
// [R2] idle-stop bit freezes port during chip idle
// [R3] bits 14, 12, 11 read as zero
// [R4] element count: master pending, slave unread
// [R5] shifter-empty flag shows idle shift register
// [R6] overrun on full receive; word dropped, sticky
// [R7] receive-empty flag shows receive fifo empty
// [R8] interrupt select acts only in enhanced mode
// [R9] select 111: transmit buffer full
// [R10] select 110: load empties transmit fifo
// [R11] select 101: last bit shifted out
// [R12] select 100: word loaded, one slot free
// [R13] select 011: receive buffer full
// [R14] select 010: receive three quarters full
// [R15] select 001: receive data available
// [R16] select 000: last word read out
// [R17] full flags read-only, hardware driven, reset zero

// register byte offsets
`define SPS_OFF_STATUS 8'h00
`define SPS_OFF_BUFFER 8'h04
`define SPS_OFF_CONFIG 8'h08

// serial_status_control field positions
`define SPS_BIT_PORT_ON 15
`define SPS_BIT_HALT_IDLE 13
`define SPS_BIT_BEC_LSB 8
`define SPS_BIT_SHIFT_EMPTY 7
`define SPS_BIT_OVERRUN 6
`define SPS_BIT_RX_EMPTY 5
`define SPS_BIT_SEL_LSB 2
`define SPS_BIT_TX_FULL 1
`define SPS_BIT_RX_FULL 0

// configuration register field positions
`define SPS_BIT_CFG_MASTER 0
`define SPS_BIT_CFG_ENHANCED 1

// reset values and bus answers
`define SPS_STATUS_RESET 16'h0000
`define SPS_RESP_OKAY 2'h0
`define SPS_RESP_SLVERR 2'h2

// timing: clock period and least half period of the generated serial clock
`define SPS_CLK_PERIOD_NS 5
`define SPS_SCK_HALF_NS 160
`endif

// ===== verilog/sps_pkg.sv
// types shared by the serial port files
`default_nettype none
package sps_pkg;
    // shift engine states, gray along idle-run-done
    typedef enum logic [1:0] {
        ENG_IDLE = 2'b00,
        ENG_RUN = 2'b01,
        ENG_DONE = 2'b11
    } sps_eng_t;

    // pins as seen from the outside
    typedef struct packed {
        logic sck;
        logic sdi;
        logic ss_n;
    } sps_pin_in_t;

    // pins driven by the port, each with its enable
    typedef struct packed {
        logic sck;
        logic sck_oe;
        logic sdo;
        logic sdo_oe;
        logic ss_n;
        logic ss_oe;
    } sps_pin_out_t;
endpackage
`default_nettype wire

// ===== verilog/sps_word_mem.sv
// small word memory with registered, write-through read data
`default_nettype none
module sps_word_mem #(
    parameter int W = 16,
    parameter int AW = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [W-1:0] wr_data,
    // read port
    input wire logic [AW-1:0] rd_addr,
    output logic [W-1:0] rd_data
);
    logic [W-1:0] mem [0:(1<<AW)-1];

    // storage has no reset; a bus read of an empty receive fifo returns the stale or unwritten entry at its read pointer
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // write-through so a word pushed into an empty fifo is visible next cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data <= '0;
        end else if (wr_en && wr_addr == rd_addr) begin
            rd_data <= wr_data;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule
`default_nettype wire

// ===== verilog/sps_status_port.sv
// serial port with status/control register, fifos and buffer interrupt select
//
// The AXI4-Lite slave port and the register addresses were decided locally.
`default_nettype none
`include "sps_map.svh"
module sps_status_port #(
    parameter int W = 16,
    parameter int DEPTH = 4,
    parameter int SCK_HALF_CYCLES = (`SPS_SCK_HALF_NS + `SPS_CLK_PERIOD_NS - 1) / `SPS_CLK_PERIOD_NS
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // chip power state
    input wire logic chip_idle,
    // axi4-lite write channels
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read channels
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // serial pins
    input wire sps_pkg::sps_pin_in_t pin_in,
    output sps_pkg::sps_pin_out_t pin_out,
    // buffer interrupt
    output logic buffer_irq
);
    import sps_pkg::*;

    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] s3;
        logic [2:0] filt;
        logic port_on;
        logic halt_in_idle;
        logic overrun;
        logic master;
        logic enhanced;
        logic [2:0] sel;
        logic [AW-1:0] tx_wp;
        logic [AW-1:0] tx_rp;
        logic [AW-1:0] rx_wp;
        logic [AW-1:0] rx_rp;
        logic [CW-1:0] tx_cnt;
        logic [CW-1:0] rx_cnt;
        sps_eng_t eng;
        logic [W-1:0] shreg;
        logic [4:0] bitcnt;
        logic [7:0] div;
        sps_pin_out_t pins;
        logic irq;
        logic aw_got;
        logic w_got;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [7:0] raddr;
    } sps_state_t;

    sps_state_t st;
    sps_state_t next_st;
    logic [CW-1:0] limit;
    logic tx_full;
    logic rx_full;
    logic active;
    logic sck_rise;
    logic sck_fall;
    logic tx_push;
    logic tx_pop;
    logic rx_push;
    logic rx_pop;
    logic done_evt;
    logic [15:0] stat;
    logic [W-1:0] tx_rd;
    logic [W-1:0] rx_rd;

    // ****************************************
    // fifo storage
    // ****************************************
    sps_word_mem #(.W(W), .AW(AW)) u_tx_mem (
        .clk(clk),
        .rst(rst),
        .wr_en(tx_push),
        .wr_addr(st.tx_wp),
        .wr_data(st.wdata[W-1:0]),
        .rd_addr(next_st.tx_rp),
        .rd_data(tx_rd)
    );

    sps_word_mem #(.W(W), .AW(AW)) u_rx_mem (
        .clk(clk),
        .rst(rst),
        .wr_en(rx_push),
        .wr_addr(st.rx_wp),
        .wr_data(st.shreg),
        .rd_addr(next_st.rx_rp),
        .rd_data(rx_rd)
    );

    // ****************************************
    // next-state logic
    // ****************************************
    // bus, pin sampling, shift engine and interrupt select in one pass
    always_comb begin
        next_st = st;
        tx_push = 1'b0;
        tx_pop = 1'b0;
        rx_push = 1'b0;
        rx_pop = 1'b0;
        done_evt = 1'b0;
        // standard mode behaves as a single-word buffer
        limit = st.enhanced ? CW'(DEPTH) : CW'(1);
        tx_full = st.tx_cnt >= limit; // R17
        rx_full = st.rx_cnt >= limit; // R17
        active = st.port_on && !(chip_idle && st.halt_in_idle); // R2

        // three-stage sampling, a change counts once stages two and three agree
        next_st.s1 = {pin_in.sck, pin_in.sdi, pin_in.ss_n};
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < 3; i++) begin
            if (st.s2[i] == st.s3[i]) begin
                next_st.filt[i] = st.s2[i];
            end
        end
        sck_rise = next_st.filt[2] && !st.filt[2];
        sck_fall = !next_st.filt[2] && st.filt[2];

        // status word, unimplemented bits stay zero
        stat = `SPS_STATUS_RESET; // R3
        stat[`SPS_BIT_PORT_ON] = st.port_on;
        stat[`SPS_BIT_HALT_IDLE] = st.halt_in_idle;
        stat[`SPS_BIT_BEC_LSB +: 3] = st.master ? 3'(st.tx_cnt) : 3'(st.rx_cnt); // R4
        stat[`SPS_BIT_SHIFT_EMPTY] = st.eng == ENG_IDLE; // R5
        stat[`SPS_BIT_OVERRUN] = st.overrun;
        stat[`SPS_BIT_RX_EMPTY] = st.rx_cnt == '0; // R7
        stat[`SPS_BIT_SEL_LSB +: 3] = st.sel;
        stat[`SPS_BIT_TX_FULL] = tx_full; // R17
        stat[`SPS_BIT_RX_FULL] = rx_full; // R17

        // write channels: address and data in either order
        if (s_axi_awvalid && st.awready) begin
            next_st.aw_got = 1'b1;
            next_st.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.wready) begin
            next_st.w_got = 1'b1;
            next_st.wdata = s_axi_wdata;
            next_st.wstrb = s_axi_wstrb;
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        if (st.aw_got && st.w_got) begin
            next_st.aw_got = 1'b0;
            next_st.w_got = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = `SPS_RESP_OKAY;
            case (st.awaddr)
                `SPS_OFF_STATUS: begin
                    if (st.wstrb[1]) begin
                        next_st.port_on = st.wdata[`SPS_BIT_PORT_ON]; // R1
                        next_st.halt_in_idle = st.wdata[`SPS_BIT_HALT_IDLE]; // R2
                    end
                    if (st.wstrb[0]) begin
                        next_st.sel = st.wdata[`SPS_BIT_SEL_LSB +: 3];
                        // writing zero clears; a same-cycle overrun below still sets it
                        if (!st.wdata[`SPS_BIT_OVERRUN]) begin
                            next_st.overrun = 1'b0; // R6
                        end
                    end
                end
                `SPS_OFF_BUFFER: begin
                    // a write into a full transmit buffer is dropped
                    tx_push = (st.wstrb[1:0] != 2'h0) && !tx_full;
                end
                `SPS_OFF_CONFIG: begin
                    if (st.wstrb[0]) begin
                        next_st.master = st.wdata[`SPS_BIT_CFG_MASTER];
                        next_st.enhanced = st.wdata[`SPS_BIT_CFG_ENHANCED];
                    end
                end
                default: begin
                    next_st.bresp = `SPS_RESP_SLVERR;
                end
            endcase
        end
        next_st.awready = !next_st.aw_got && !next_st.bvalid;
        next_st.wready = !next_st.w_got && !next_st.bvalid;

        // read channels: data returned on the edge that takes the address
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st.arready) begin
            next_st.rvalid = 1'b1;
            next_st.raddr = s_axi_araddr;
            next_st.rresp = `SPS_RESP_OKAY;
            next_st.rdata = '0;
            case (s_axi_araddr)
                `SPS_OFF_STATUS: begin
                    next_st.rdata = 32'(stat);
                end
                `SPS_OFF_BUFFER: begin
                    next_st.rdata = 32'(rx_rd);
                    rx_pop = st.rx_cnt != '0;
                end
                `SPS_OFF_CONFIG: begin
                    next_st.rdata = 32'({st.enhanced, st.master});
                end
                default: begin
                    next_st.rresp = `SPS_RESP_SLVERR;
                end
            endcase
        end
        next_st.arready = !next_st.rvalid;

        // shift engine, mode 0: sample on rising edge, change on falling edge
        if (!st.port_on) begin
            next_st.eng = ENG_IDLE; // R1
            next_st.bitcnt = '0;
            next_st.div = '0;
            next_st.pins = '{sck: 1'b0, sck_oe: 1'b0, sdo: 1'b0, sdo_oe: 1'b0, ss_n: 1'b1, ss_oe: 1'b0}; // R1
        end else if (active) begin
            // slave drives data only while selected, so peers can share the line
            next_st.pins.sck_oe = st.master; // R1
            next_st.pins.ss_oe = st.master;
            next_st.pins.sdo_oe = st.master || !st.filt[0];
            case (st.eng)
                ENG_IDLE: begin
                    next_st.bitcnt = '0;
                    next_st.div = '0;
                    next_st.pins.sck = 1'b0;
                    if (st.master ? (st.tx_cnt != '0) : !st.filt[0]) begin
                        // a selected slave with nothing queued sends zeros
                        tx_pop = st.tx_cnt != '0;
                        next_st.shreg = tx_pop ? tx_rd : '0;
                        next_st.pins.sdo = tx_pop ? tx_rd[W-1] : 1'b0;
                        next_st.pins.ss_n = !st.master;
                        next_st.eng = ENG_RUN;
                    end
                end
                ENG_RUN: begin
                    if (st.master) begin
                        next_st.div = st.div + 8'h01;
                        if (st.div == 8'(SCK_HALF_CYCLES - 1)) begin
                            next_st.div = '0;
                            next_st.pins.sck = !st.pins.sck;
                            if (!st.pins.sck) begin
                                next_st.shreg = {st.shreg[W-2:0], st.filt[1]};
                                next_st.bitcnt = st.bitcnt + 5'h01;
                            end else if (st.bitcnt == 5'(W)) begin
                                next_st.eng = ENG_DONE;
                            end else begin
                                next_st.pins.sdo = st.shreg[W-1];
                            end
                        end
                    end else if (st.filt[0]) begin
                        // deselect mid-word abandons it
                        next_st.eng = ENG_IDLE;
                    end else if (sck_rise) begin
                        next_st.shreg = {st.shreg[W-2:0], st.filt[1]};
                        next_st.bitcnt = st.bitcnt + 5'h01;
                        if (st.bitcnt == 5'(W - 1)) begin
                            next_st.eng = ENG_DONE;
                        end
                    end else if (sck_fall) begin
                        next_st.pins.sdo = st.shreg[W-1];
                    end
                end
                ENG_DONE: begin
                    done_evt = 1'b1;
                    next_st.pins.ss_n = 1'b1;
                    next_st.eng = ENG_IDLE;
                    if (rx_full) begin
                        next_st.overrun = 1'b1; // R6
                    end else begin
                        rx_push = 1'b1;
                    end
                end
                default: begin
                    next_st.eng = ENG_IDLE;
                end
            endcase
        end

        // fifo pointers and counts
        next_st.tx_wp = tx_push ? st.tx_wp + AW'(1) : st.tx_wp;
        next_st.tx_rp = tx_pop ? st.tx_rp + AW'(1) : st.tx_rp;
        next_st.rx_wp = rx_push ? st.rx_wp + AW'(1) : st.rx_wp;
        next_st.rx_rp = rx_pop ? st.rx_rp + AW'(1) : st.rx_rp;
        next_st.tx_cnt = st.tx_cnt + CW'(tx_push) - CW'(tx_pop);
        next_st.rx_cnt = st.rx_cnt + CW'(rx_push) - CW'(rx_pop);

        // buffer interrupt: select honoured in enhanced mode, else each received word
        if (st.enhanced) begin
            case (st.sel) // R8
                3'h7: next_st.irq = tx_full; // R9
                3'h6: next_st.irq = tx_pop && next_st.tx_cnt == '0; // R10
                3'h5: next_st.irq = done_evt; // R11
                3'h4: next_st.irq = tx_pop; // R12
                3'h3: next_st.irq = rx_full; // R13
                3'h2: next_st.irq = int'(st.rx_cnt) * 4 >= int'(limit) * 3; // R14
                3'h1: next_st.irq = st.rx_cnt != '0; // R15
                3'h0: next_st.irq = rx_pop && next_st.rx_cnt == '0; // R16
                default: next_st.irq = 1'b0;
            endcase
        end else begin
            next_st.irq = rx_push;
        end
    end

    // ****************************************
    // state register
    // ****************************************
    // select lines reset high so an enabled slave does not see a phantom select
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '0; // R17
            st.s1 <= 3'h1;
            st.s2 <= 3'h1;
            st.s3 <= 3'h1;
            st.filt <= 3'h1;
            st.pins.ss_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    assign s_axi_awready = st.awready;
    assign s_axi_wready = st.wready;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rresp = st.rresp;
    assign s_axi_rdata = st.rdata;
    assign pin_out = st.pins;
    assign buffer_irq = st.irq;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_full_done;
        st.port_on && st.eng == ENG_DONE && rx_full && !(chip_idle && st.halt_in_idle);
    endsequence
    property p_overrun_set;
        s_full_done |=> st.overrun && $stable(st.rx_wp);
    endproperty
    a_overrun_set: assert property (p_overrun_set) else $error("overrun not flagged"); // R6
    property p_rsv_zero;
        (st.rvalid && st.raddr == `SPS_OFF_STATUS) |-> st.rdata[14] == 1'b0 && st.rdata[12:11] == 2'h0;
    endproperty
    a_rsv_zero: assert property (p_rsv_zero) else $error("unimplemented bits nonzero"); // R3
    property p_port_off;
        !st.port_on |=> !st.pins.sck_oe && !st.pins.sdo_oe && !st.pins.ss_oe && st.eng == ENG_IDLE;
    endproperty
    a_port_off: assert property (p_port_off) else $error("disabled port still drives"); // R1
    property p_idle_hold;
        (st.port_on && chip_idle && st.halt_in_idle) |=> $stable(st.eng) && $stable(st.bitcnt);
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("port moved while idle-halted"); // R2
    property p_irq_txfull;
        (st.enhanced && st.sel == 3'h7 && tx_full) |=> st.irq;
    endproperty
    a_irq_txfull: assert property (p_irq_txfull) else $error("no irq on transmit full"); // R9
    property p_irq_rxfull;
        (st.enhanced && st.sel == 3'h3) |=> (st.irq == $past(rx_full));
    endproperty
    a_irq_rxfull: assert property (p_irq_rxfull) else $error("irq does not follow receive full"); // R13
    property p_irq_avail;
        (st.enhanced && st.sel == 3'h1 && st.rx_cnt != '0) |=> st.irq;
    endproperty
    a_irq_avail: assert property (p_irq_avail) else $error("no irq with data available"); // R15
    sequence s_load;
        st.enhanced && st.sel == 3'h4 && tx_pop;
    endsequence
    // a slave may be deselected right after the load, so only the load cycle itself is checked
    property p_irq_load;
        s_load |=> st.irq && st.eng == ENG_RUN;
    endproperty
    a_irq_load: assert property (p_irq_load) else $error("no irq on shifter load"); // R12
    // only the first answer cycle: a stalled rready leaves rdata stale while the engine moves on
    property p_shift_empty;
        ($rose(st.rvalid) && st.raddr == `SPS_OFF_STATUS) |-> st.rdata[7] == ($past(st.eng) == ENG_IDLE);
    endproperty
    a_shift_empty: assert property (p_shift_empty) else $error("shifter-empty flag wrong"); // R5
endmodule
`default_nettype wire

// ===== tb/sps_peer.sv
// behavioural spi peer facing the serial port pins
`default_nettype none
module sps_peer (
    // pins of the port
    input wire sps_pkg::sps_pin_out_t pin_out,
    output sps_pkg::sps_pin_in_t pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    import sps_pkg::*;
    // ********
    // link state
    // ********
    logic m_sck = 1'b0;
    logic m_ss_n = 1'b1;
    logic sdi = 1'b0;
    logic [15:0] reply = 16'ha5c3;
    logic [15:0] got = 16'h0000;
    int idx = 0;
    // own clock and select only where the port leaves them undriven
    assign pin_in.sck = pin_out.sck_oe ? pin_out.sck : m_sck;
    assign pin_in.sdi = sdi;
    assign pin_in.ss_n = pin_out.ss_oe ? pin_out.ss_n : m_ss_n;
    // slave side: first bit ready at select, next one on each fall
    always @(negedge pin_out.ss_n) begin
        idx = 15;
        sdi = reply[15];
    end
    always @(posedge pin_out.sck) begin
        if (!pin_out.ss_n) begin
            got = {got[14:0], pin_out.sdo};
        end
    end
    always @(negedge pin_out.sck) begin
        if (!pin_out.ss_n && idx > 0) begin
            idx = idx - 1;
            sdi = reply[idx];
        end
    end
    // released line keeps no value, so the port cannot lean on it
    always @(posedge pin_out.ss_n) begin
        sdi = ~sdi;
    end
    // master side: 64 ns clock, still outside the frame
    task automatic send(input logic [15:0] w);
        m_ss_n = 1'b0;
        sdi = w[15];
        #64;
        for (int i = 15; i >= 0; i--) begin
            sdi = w[i];
            #32 m_sck = 1'b1;
            #32 m_sck = 1'b0;
        end
        #64 m_ss_n = 1'b1;
        sdi = ~sdi;
    endtask
endmodule
`default_nettype wire

// ===== tb/sps_status_port_test.sv
// self-checking bench of the serial port status and interrupt block
`default_nettype none
`include "sps_map.svh"
module sps_status_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    import sps_pkg::*;
    // ********
    // bench
    // ********
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic idle = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata, rd_q;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, resp_q;
    sps_pin_in_t pin_in;
    sps_pin_out_t pin_out;
    int bad_count = 0, n_tests = 0, cycles = 0, pulses = 0, p0 = 0;
    logic [2:0] sels [4] = '{3'h7, 3'h4, 3'h6, 3'h5};
    int npush [4] = '{4, 2, 2, 2};
    int npulse [4] = '{-1, 2, 1, 2};
    sps_status_port #(.SCK_HALF_CYCLES(8)) dut_u (
        .clk(clk), .rst(rst), .chip_idle(idle),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .pin_in(pin_in), .pin_out(pin_out), .buffer_irq(irq)
    );
    sps_peer peer_u (.pin_out(pin_out), .pin_in(pin_in));
    initial begin
        forever #2.5 clk = ~clk;
    end
    // one-cycle interrupts cannot be polled over the bus, so count them here
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (irq === 1'b1) begin
            pulses <= pulses + 1;
        end
        if (cycles == 30000) begin
            bad_count++;
            summarize();
        end
    end
    // verdict and end of run
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        n_tests++;
        if (got !== want) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, want);
        end
    endtask
    // bus cycles; a trailing edge keeps two tasks from touching a signal at once
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        awaddr <= a;
        wdata <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        fork
            begin
                do @(posedge clk); while (!awready);
                awvalid <= 1'b0;
            end
            begin
                do @(posedge clk); while (!wready);
                wvalid <= 1'b0;
            end
        join
        do @(posedge clk); while (!bvalid);
        resp_q = bresp;
        bready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
        rd_q = rdata;
        resp_q = rresp;
        rready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic st(input logic [15:0] mask, input logic [15:0] want);
        rd(`SPS_OFF_STATUS);
        chk(rd_q & {16'h0000, mask}, {16'h0000, want});
    endtask
    task automatic rx_word(input logic [15:0] w);
        peer_u.send(w);
        repeat (8) @(posedge clk);
    endtask
    // poll until nothing is pending and the shifter is idle
    task automatic done_wait();
        for (int t = 0; t < 500; t++) begin
            rd(`SPS_OFF_STATUS);
            if (rd_q[10:8] === 3'h0 && rd_q[7] === 1'b1) begin
                break;
            end
        end
        repeat (3) @(posedge clk);
    endtask
    // main sequence: slave receive paths first, then master transmit
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        st(16'hf843, 16'h0000);
        rd(8'h0c);
        chk(resp_q, `SPS_RESP_SLVERR);
        wr(8'h0c, 16'hffff);
        chk(resp_q, `SPS_RESP_SLVERR);
        wr(`SPS_OFF_STATUS, 16'hffff);
        st(16'hf85f, 16'ha01c);
        wr(`SPS_OFF_STATUS, 16'h8004);
        p0 = pulses;
        rx_word(16'h3c5a);
        chk(irq, 1'b0);
        chk(pulses - p0, 1);
        rd(`SPS_OFF_BUFFER);
        chk(rd_q, 32'h0000_3c5a);
        wr(`SPS_OFF_CONFIG, 16'h0002);
        for (int n = 1; n <= 5; n++) begin
            rx_word(16'h0f00 + 16'(n));
            if (n < 5) begin
                for (int s = 1; s <= 3; s++) begin
                    wr(`SPS_OFF_STATUS, 16'h8000 | 16'(s) << 2);
                    repeat (3) @(posedge clk);
                    chk(irq, s == 1 || (s == 2 && n >= 3) || n == 4);
                end
                st(16'h0720, 16'(n) << 8);
            end
        end
        st(16'h0763, 16'h0441);
        wr(`SPS_OFF_STATUS, 16'h8000);
        p0 = pulses;
        for (int n = 1; n <= 4; n++) begin
            rd(`SPS_OFF_BUFFER);
            chk(rd_q, 32'h0000_0f00 + 32'(n));
        end
        repeat (3) @(posedge clk);
        chk(pulses - p0, 1);
        st(16'h0760, 16'h0020);
        wr(`SPS_OFF_CONFIG, 16'h0003);
        wr(`SPS_OFF_STATUS, 16'h0000);
        repeat (3) @(posedge clk);
        chk({pin_out.sck_oe, pin_out.sdo_oe, pin_out.ss_oe}, 0);
        idle <= 1'b1;
        for (int b = 0; b < 4; b++) begin
            wr(`SPS_OFF_STATUS, 16'ha000 | 16'(sels[b]) << 2);
            for (int i = 0; i < npush[b]; i++) begin
                wr(`SPS_OFF_BUFFER, 16'hc300 + 16'(i));
            end
            repeat (3) @(posedge clk);
            st(16'h0782, 16'(npush[b]) << 8 | 16'h0080 | (b == 0 ? 16'h0002 : 16'h0000));
            chk(irq, b == 0);
            p0 = pulses;
            idle <= 1'b0;
            repeat (20) @(posedge clk);
            chk(pin_out.sck_oe, 1);
            st(16'h0080, 16'h0000);
            done_wait();
            if (npulse[b] >= 0) begin
                chk(pulses - p0, npulse[b]);
            end
            chk(peer_u.got, 16'hc300 + 16'(npush[b] - 1));
            idle <= 1'b1;
        end
        rd(`SPS_OFF_BUFFER);
        chk(rd_q, 32'h0000_a5c3);
        summarize();
    end
endmodule
`default_nettype wire
